// *** bench/sst_host_model.sv ***
`timescale 1ns/1ps

module sst_host_model (
  input  wire logic        clock_i,
  output sst_pkg::sst_cmd_t cmd_o,
  output logic [3:0]       target_o
);
  initial begin
    cmd_o    = '0;
    target_o = '0;
  end

  // one-cycle terminal strobe, launched just after an edge
  task automatic send(input logic [7:0] c, input logic [3:0] t);
    @(posedge clock_i);
    #1;
    cmd_o    = c;
    target_o = t;
    @(posedge clock_i);
    #1;
    cmd_o    = '0;
  endtask : send

  task automatic capture(input logic [3:0] t); send(8'h08, t); endtask : capture
  task automatic teach_locked(input logic [3:0] t);
    send(8'h01, t);
    send(8'h08, t);
  endtask : teach_locked
  task automatic key(input bit ok); send({5'h00, ok, !ok, 1'b0}, target_o); endtask : key
  task automatic disable_servo(); send(8'h80, target_o); endtask : disable_servo
  task automatic restore(); send(8'h40, target_o); endtask : restore
  task automatic brake(input bit arg); send({2'b00, 1'b1, arg, 4'h0}, target_o); endtask : brake
  task automatic brake_back();
    brake(1'b0);
    restore();
  endtask : brake_back
endmodule : sst_host_model

// *** bench/sst_status_teach_sva.sv ***
`timescale 1ns/1ps
`include "sst_regs.svh"

module sst_status_teach_sva #(
  parameter int POS_W = `SST_POS_W
) (
  input wire logic                     clock_i,
  input wire logic                     arst_n_i,
  input wire logic                     plus_hard_limit_i,
  input wire logic [POS_W-1:0]         cur_pos_i,
  input wire logic signed [POS_W:0]    pos_err_i,
  input wire logic                     homing_done_i,
  input wire logic                     homing_abort_i,
  input wire sst_pkg::sst_alarm_t      alarm_i,
  input wire sst_pkg::sst_cmd_t        cmd_i,
  input wire logic [`SST_TGT_W-1:0]    teach_target_i,
  input wire sst_pkg::sst_status_t     status_o,
  input wire logic [`SST_ALM_W-1:0]    alarm_query_o,
  input wire logic                     servo_on_o,
  input wire logic                     brake_active_o,
  input wire sst_pkg::sst_edit_state_t edit_state_o,
  input wire logic [POS_W-1:0]         edit_display_o,
  input wire logic                     prog_store_o,
  input wire logic [POS_W-1:0]         prog_target_o,
  input wire logic                     prog_is_angle_o
);
  // ---------------------------------------------------------------
  // helpers and sequences
  // ---------------------------------------------------------------
  logic signed [POS_W+1:0] cmd_pos;
  logic                    cmd_zero;
  logic                    org_alm;
  assign cmd_pos  = $signed({2'b00, cur_pos_i}) + pos_err_i;
  assign cmd_zero = (cmd_pos == '0);
  assign org_alm  = alarm_i.sensor_err | alarm_i.abspos_err | alarm_i.over_speed;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_cap_idle;
    cmd_i.capture_suffix && teach_target_i == `SST_TGT_AR
      && edit_state_o == sst_pkg::SST_EDIT_IDLE;
  endsequence
  sequence s_home_zero;
    homing_done_i && cmd_zero ##1 cmd_zero [*3];
  endsequence

  a_limit_close : assert property (
    plus_hard_limit_i [*4] |=> status_o.travel_limit_flag)
    else $error("travel flag open on limit");
  a_hard_code : assert property (
    (plus_hard_limit_i && !org_alm) [*4] |=> alarm_query_o == `SST_ALM_HARD_OT)
    else $error("hard limit code wrong");
  a_alarm_opens : assert property (
    (alarm_i.other_alarm || alarm_i.warning) [*2] |=> !status_o.healthy_flag)
    else $error("healthy flag closed on alarm");
  a_home_close : assert property (
    s_home_zero |=> status_o.homing_done_flag)
    else $error("homing flag not closed");
  a_home_reopen : assert property (
    !cmd_zero ##1 (!homing_done_i) [*2] |=> !status_o.homing_done_flag)
    else $error("homing flag closed off zero");
  a_origin_alarm : assert property (
    org_alm [*2] |=> !status_o.origin_defined_flag && !servo_on_o)
    else $error("origin alarm ignored");
  a_abort_undef : assert property (
    homing_abort_i ##1 (!homing_done_i) [*2] |=> !status_o.origin_defined_flag)
    else $error("abort kept origin");
  a_clamp_range : assert property (
    prog_store_o |-> prog_target_o <= (prog_is_angle_o ? `SST_ANG_MAX : `SST_POS_MAX))
    else $error("stored target out of range");
  a_disable_lock : assert property (
    cmd_i.servo_disable_cmd ##1 (!cmd_i.servo_restore_cmd) [*2] |=> !servo_on_o)
    else $error("servo on after disable");
  a_brake_arg : assert property (
    cmd_i.brake_release_cmd |=> brake_active_o == !$past(cmd_i.brake_release_arg))
    else $error("brake state wrong");
  a_edit_show : assert property (
    s_cap_idle |=> edit_state_o == sst_pkg::SST_EDIT_SHOW
      && edit_display_o == $past(cur_pos_i))
    else $error("edit capture not shown");
  a_edit_accept : assert property (
    edit_state_o == sst_pkg::SST_EDIT_SHOW && cmd_i.accept_key |=> prog_store_o
      && (prog_is_angle_o || prog_target_o == $past(edit_display_o)))
    else $error("accept did not store shown value");
endmodule : sst_status_teach_sva

bind sst_status_teach sst_status_teach_sva #(.POS_W(POS_W)) sst_status_teach_sva_i (.*);

// *** bench/tb.sv ***
`timescale 1ns/1ps
`include "sst_regs.svh"

module tb;
  logic                     clock_i = 1'b0;
  logic                     arst_n_i, servo_enable_input_i, homing_start_input_i;
  logic                     plus_hard_limit_i, minus_hard_limit_i, moving_i, move_done_i;
  logic                     homing_done_i, homing_abort_i, teach_reject_o, prog_store_o;
  logic [21:0]              cur_pos_i, param_data_o, edit_display_o, prog_target_o;
  logic signed [22:0]       pos_err_i;
  logic [15:0]              cur_ang_i;
  logic [3:0]               teach_target_i, param_sel_i;
  logic [7:0]               alarm_query_o;
  logic                     plus_limit_flag_o, minus_limit_flag_o, driver_ready_flag_o;
  logic                     warning_flag_o, servo_on_o, brake_active_o, stop_motion_o;
  logic                     prog_is_angle_o, rej_seen, st_seen, st_ang;
  logic [21:0]              st_tgt, p, exp_mem [9];
  sst_pkg::sst_alarm_t      alarm_i;
  sst_pkg::sst_cmd_t        cmd_i;
  sst_pkg::sst_status_t     status_o;
  sst_pkg::sst_edit_state_t edit_state_o;
  logic [7:0]               codes [3] = '{`SST_ALM_SENSOR, `SST_ALM_ABSPOS, `SST_ALM_OVERSPD};
  bit                       pw_given;
  int                       fails, num_checks, cycles, k;

  sst_status_teach sst_status_teach_i (.*);
  sst_host_model host (.clock_i(clock_i), .cmd_o(cmd_i), .target_o(teach_target_i));

  always #4 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    cycles++;
    if (teach_reject_o === 1'b1) rej_seen <= 1'b1;
    if (prog_store_o === 1'b1) begin
      st_seen <= 1'b1;
      st_tgt  <= prog_target_o;
      st_ang  <= prog_is_angle_o;
    end
    if (cycles > 4000) begin
      fails++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude();
    if ((fails == 0) && (num_checks > 0)) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse

  function automatic logic [21:0] clamp(input logic [21:0] v);
    return (v > `SST_POS_MAX) ? `SST_POS_MAX : v;
  endfunction : clamp

  task automatic teach(input logic [3:0] t, input logic [21:0] v, input bit pw);
    logic exp_rej;
    pw_given  = pw_given | pw;
    exp_rej   = (t < 4'h3) && !pw_given;
    cur_pos_i = v;
    rej_seen  = 1'b0;
    if (pw) host.teach_locked(t);
    else host.capture(t);
    if (!exp_rej) exp_mem[t] = (t == 4'h2) ? v : clamp(v);
    cyc(3);
    chk(rej_seen, exp_rej);
    param_sel_i = t;
    cyc(3);
    chk(param_data_o, exp_mem[t]);
  endtask : teach

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(63));
    {arst_n_i, servo_enable_input_i, homing_start_input_i, plus_hard_limit_i} = '0;
    {minus_hard_limit_i, moving_i, move_done_i, homing_done_i, homing_abort_i} = '0;
    {cur_pos_i, pos_err_i, cur_ang_i, param_sel_i, alarm_i} = '0;
    {rej_seen, st_seen, st_ang, st_tgt} = '0;
    foreach (exp_mem[i]) exp_mem[i] = '0;
    repeat (3) @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
    cyc(2);
    moving_i = 1'b1;
    for (k = 0; k < 4; k++) begin
      {minus_hard_limit_i, plus_hard_limit_i} = k[1:0];
      cyc(4);
      chk(status_o.travel_limit_flag, k != 0);
      chk({plus_limit_flag_o, minus_limit_flag_o}, {k[0], k[1]});
      chk(alarm_query_o, (k != 0) ? `SST_ALM_HARD_OT : `SST_ALM_NONE);
      chk(status_o.healthy_flag, k == 0);
      chk({stop_motion_o, status_o.in_position_flag}, {k != 0, 1'b0});
    end
    {minus_hard_limit_i, plus_hard_limit_i, moving_i} = '0;
    cyc(3);
    pulse(move_done_i);
    cyc(2);
    plus_hard_limit_i = 1'b1;
    cyc(4);
    chk(status_o.in_position_flag, 1'b1);
    plus_hard_limit_i = 1'b0;
    for (k = 0; k < 2; k++) begin
      alarm_i = 7'h01 << k;
      cyc(3);
      chk(status_o.healthy_flag, 1'b0);
      chk({driver_ready_flag_o, warning_flag_o}, (k != 0) ? 2'b00 : 2'b11);
    end
    alarm_i = '0;
    cyc(4);
    chk({status_o.healthy_flag, driver_ready_flag_o}, 2'b11);
    servo_enable_input_i = 1'b1;
    cyc(4);
    chk({servo_on_o, brake_active_o}, 2'b11);
    host.disable_servo();
    cyc(3);
    chk(servo_on_o, 1'b0);
    host.brake(1'b1);
    cyc(2);
    chk(brake_active_o, 1'b0);
    host.restore();
    cyc(2);
    chk(servo_on_o, 1'b0);
    host.brake_back();
    cyc(4);
    chk({brake_active_o, servo_on_o}, 2'b11);
    pulse(homing_done_i);
    cyc(3);
    chk({status_o.origin_defined_flag, status_o.homing_done_flag}, 2'b11);
    pos_err_i = 23'($urandom_range(1, 1000));
    cyc(3);
    chk({status_o.origin_defined_flag, status_o.homing_done_flag}, 2'b10);
    pos_err_i = '0;
    cyc(3);
    chk(status_o.homing_done_flag, 1'b0);
    p = 22'($urandom_range(1, 2621439));
    cur_pos_i = p;
    pos_err_i = -$signed({1'b0, p});
    pulse(homing_done_i);
    cyc(3);
    chk(status_o.homing_done_flag, 1'b1);
    for (k = 0; k < 3; k++) begin
      alarm_i = 7'h10 >> k;
      cyc(3);
      chk({status_o.origin_defined_flag, servo_on_o}, 2'b00);
      chk(alarm_query_o, codes[k]);
      alarm_i = '0;
      pulse(homing_done_i);
      cyc(3);
      chk(status_o.origin_defined_flag, 1'b1);
    end
    homing_start_input_i = 1'b1;
    cyc(3);
    homing_start_input_i = 1'b0;
    cyc(2);
    pulse(homing_abort_i);
    cyc(3);
    chk(status_o.origin_defined_flag, 1'b0);
    p = 22'($urandom_range(0, 2621439));
    cur_pos_i = p;
    st_seen = 1'b0;
    host.capture(4'h9);
    cyc(1);
    chk({edit_state_o, edit_display_o}, {sst_pkg::SST_EDIT_SHOW, p});
    cur_pos_i = '0;
    host.key(1'b1);
    cyc(3);
    chk({st_seen, st_ang, st_tgt, edit_state_o}, {2'b10, p, sst_pkg::SST_EDIT_IDLE});
    cur_ang_i = 16'hffff;
    host.capture(4'ha);
    cyc(2);
    host.key(1'b1);
    cyc(3);
    chk({st_ang, st_tgt}, {1'b1, 6'h00, `SST_ANG_MAX});
    p = 22'($urandom_range(0, 35999));
    cur_ang_i = p[15:0];
    host.capture(4'ha);
    cyc(2);
    host.key(1'b1);
    cyc(3);
    chk({st_ang, st_tgt}, {1'b1, p});
    host.capture(4'h9);
    cyc(2);
    st_seen = 1'b0;
    host.key(1'b0);
    cyc(3);
    chk({st_seen, edit_state_o}, {1'b0, sst_pkg::SST_EDIT_IDLE});
    teach(4'h3, 22'h3fffff, 1'b0);
    for (k = 4; k < 9; k++) teach(k[3:0], 22'($urandom_range(0, 2621439)), 1'b0);
    teach(4'h0, 22'($urandom_range(1, 2621439)), 1'b0);
    for (k = 0; k < 3; k++) teach(k[3:0], 22'($urandom_range(1, 2621439)), 1'b1);
    conclude();
  end
endmodule : tb

// *** src/sst_param_mem.sv ***
`timescale 1ns/1ps
`include "sst_regs.svh"

module sst_param_mem #(
  parameter int DEPTH = `SST_NUM_PARAMS,
  parameter int WIDTH = `SST_POS_W
) (
  input  wire logic                     clock_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic      [WIDTH-1:0]         rd_data_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  initial begin
    if (DEPTH < 2) $error("sst_param_mem: DEPTH too small");
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
    end else if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) rd_data_o <= '0;
    else rd_data_o <= mem_reg[rd_addr_i];
  end

endmodule : sst_param_mem

// *** src/sst_pin_sync.sv ***
`timescale 1ns/1ps

module sst_pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) $error("sst_pin_sync: WIDTH must be positive");
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= pin_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : sst_pin_sync

// *** src/sst_pkg.sv ***
package sst_pkg;

  // alarm inputs from the fault detectors
  typedef struct packed {
    logic soft_ot;
    logic hard_ot;
    logic sensor_err;
    logic abspos_err;
    logic over_speed;
    logic other_alarm;
    logic warning;
  } sst_alarm_t;

  // status outputs to the host
  typedef struct packed {
    logic travel_limit_flag;
    logic in_position_flag;
    logic healthy_flag;
    logic homing_done_flag;
    logic origin_defined_flag;
  } sst_status_t;

  // terminal command strobes, one-cycle pulses
  typedef struct packed {
    logic servo_disable_cmd;
    logic servo_restore_cmd;
    logic brake_release_cmd;
    logic brake_release_arg;
    logic capture_suffix;
    logic accept_key;
    logic cancel_key;
    logic password_ok;
  } sst_cmd_t;

  typedef enum logic [1:0] {
    SST_EDIT_IDLE = 2'b00,
    SST_EDIT_SHOW = 2'b01,
    SST_EDIT_DONE = 2'b10
  } sst_edit_state_t;

endpackage : sst_pkg

// *** src/sst_regs.svh ***
`ifndef SST_REGS_SVH
`define SST_REGS_SVH

// position and angle ranges
`define SST_POS_W        22
`define SST_POS_MAX      22'd2621439
`define SST_ANG_W        16
`define SST_ANG_MAX      16'd35999

// alarm codes reported to the alarm query
`define SST_ALM_W        8
`define SST_ALM_NONE     8'h00
`define SST_ALM_SOFT_OT  8'hf2
`define SST_ALM_HARD_OT  8'hf3
`define SST_ALM_SENSOR   8'ha0
`define SST_ALM_ABSPOS   8'ha1
`define SST_ALM_OVERSPD  8'ha4

// teach target selectors
`define SST_TGT_W        4
`define SST_TGT_OTP      4'h0
`define SST_TGT_OTM      4'h1
`define SST_TGT_HO       4'h2
`define SST_TGT_ZAS      4'h3
`define SST_TGT_ZAE      4'h4
`define SST_TGT_ZBS      4'h5
`define SST_TGT_ZBE      4'h6
`define SST_TGT_ZCS      4'h7
`define SST_TGT_ZCE      4'h8
`define SST_TGT_AR       4'h9
`define SST_TGT_AD       4'ha
`define SST_NUM_PARAMS   9

`endif

// *** src/sst_status_teach.sv ***
`timescale 1ns/1ps
`include "sst_regs.svh"

// Functional notes
// - travel-limit flag closed while inside soft or hard limit region.
// - travel-limit flag same for plus and minus limits.
// - limit raises alarm F2 soft, F3 hard, shown on alarm query.
// - limit during a move stops short, in-position stays open.
// - limit at rest leaves in-position as it was.
// - healthy flag closed normally, open on any alarm or warning.
// - healthy flag timed like driver-ready and warning outputs.
// - homing flag closes when homing done and commanded position is zero.
// - commanded position is current position plus position error.
// - commanded position leaving zero opens homing flag until next homing.
// - origin flag closed while origin defined, open otherwise.
// - sensor, absolute-position or over-speed alarm undefines origin, servo off.
// - interrupted homing undefines origin.
// - capture suffix loads current absolute position into the parameter.
// - taught pulses clamp 0..2621439, angles 0..35999.
// - teaching limits or origin offset needs password first.
// - after servo-disable, servo-enable input is ignored.
// - brake release 1 removes brake; 0 then restore returns normal.
// - program edit capture shows position; accept stores, cancel discards.
module sst_status_teach #(
  parameter int POS_W = `SST_POS_W,
  parameter int ANG_W = `SST_ANG_W
) (
  input  wire logic                     clock_i,
  input  wire logic                     arst_n_i,
  // pins from the field
  input  wire logic                     servo_enable_input_i,
  input  wire logic                     homing_start_input_i,
  input  wire logic                     plus_hard_limit_i,
  input  wire logic                     minus_hard_limit_i,
  // on-clock inputs from the motion core, fault detectors and terminal
  input  wire logic [POS_W-1:0]         cur_pos_i,
  input  wire logic signed [POS_W:0]    pos_err_i,
  input  wire logic [ANG_W-1:0]         cur_ang_i,
  input  wire logic                     moving_i,
  input  wire logic                     move_done_i,
  input  wire logic                     homing_done_i,
  input  wire logic                     homing_abort_i,
  input  wire sst_pkg::sst_alarm_t      alarm_i,
  input  wire sst_pkg::sst_cmd_t        cmd_i,
  input  wire logic [`SST_TGT_W-1:0]    teach_target_i,
  input  wire logic [`SST_TGT_W-1:0]    param_sel_i,
  // outputs
  output sst_pkg::sst_status_t          status_o,
  output logic                          plus_limit_flag_o,
  output logic                          minus_limit_flag_o,
  output logic                          driver_ready_flag_o,
  output logic                          warning_flag_o,
  output logic [`SST_ALM_W-1:0]         alarm_query_o,
  output logic                          servo_on_o,
  output logic                          brake_active_o,
  output logic                          stop_motion_o,
  output logic [POS_W-1:0]              param_data_o,
  output logic                          teach_reject_o,
  output sst_pkg::sst_edit_state_t      edit_state_o,
  output logic [POS_W-1:0]              edit_display_o,
  output logic                          prog_store_o,
  output logic [POS_W-1:0]              prog_target_o,
  output logic                          prog_is_angle_o
);

  initial begin
    if (POS_W < 22) $error("sst_status_teach: POS_W below 22");
    if (ANG_W < 16) $error("sst_status_teach: ANG_W below 16");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pins_sync;

  sst_pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .pin_i    ({servo_enable_input_i, homing_start_input_i,
                plus_hard_limit_i, minus_hard_limit_i}),
    .sync_o   (pins_sync)
  );

  wire servo_en_s   = pins_sync[3];
  wire homing_req_s = pins_sync[2];
  wire plus_hard_s  = pins_sync[1];
  wire minus_hard_s = pins_sync[0];

  // ----------------------------------------
  // taught limits and decoding
  // ----------------------------------------
  function automatic logic [POS_W-1:0] clamp_pos(input logic [POS_W-1:0] v);
    clamp_pos = (v > `SST_POS_MAX) ? `SST_POS_MAX : v;
  endfunction : clamp_pos

  function automatic logic needs_password(input logic [`SST_TGT_W-1:0] t);
    needs_password = (t == `SST_TGT_OTP) || (t == `SST_TGT_OTM) ||
                     (t == `SST_TGT_HO);
  endfunction : needs_password

  logic [POS_W-1:0] otp_reg;
  logic [POS_W-1:0] otm_reg;
  logic             pw_ok_reg;

  wire teach_param = cmd_i.capture_suffix && (teach_target_i < `SST_TGT_AR);
  wire teach_lock  = needs_password(teach_target_i) && !pw_ok_reg;
  wire teach_write = teach_param && !teach_lock;
  wire [POS_W-1:0] taught_pos = clamp_pos(cur_pos_i);
  wire [ANG_W-1:0] taught_ang = (cur_ang_i > `SST_ANG_MAX) ? `SST_ANG_MAX : cur_ang_i;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      otp_reg        <= '0;
      otm_reg        <= '0;
      pw_ok_reg      <= 1'b0;
      teach_reject_o <= 1'b0;
    end else begin
      if (cmd_i.password_ok) pw_ok_reg <= 1'b1;
      teach_reject_o <= teach_param && teach_lock;
      if (teach_write && teach_target_i == `SST_TGT_OTP) otp_reg <= taught_pos;
      if (teach_write && teach_target_i == `SST_TGT_OTM) otm_reg <= taught_pos;
    end
  end

  sst_param_mem #(
    .DEPTH (`SST_NUM_PARAMS),
    .WIDTH (POS_W)
  ) u_mem (
    .clock_i   (clock_i),
    .arst_n_i  (arst_n_i),
    .wr_en_i   (teach_write),
    .wr_addr_i (teach_target_i),
    .wr_data_i (taught_pos),
    .rd_addr_i (param_sel_i),
    .rd_data_o (param_data_o)
  );

  // ----------------------------------------
  // travel limits
  // ----------------------------------------
  wire soft_plus  = (otp_reg != '0) && (cur_pos_i >= otp_reg);
  wire soft_minus = (otm_reg != '0) && (cur_pos_i <= otm_reg);
  wire soft_ot    = soft_plus || soft_minus || alarm_i.soft_ot;
  wire hard_ot    = plus_hard_s || minus_hard_s || alarm_i.hard_ot;
  wire limit_hit  = soft_ot || hard_ot;

  // ----------------------------------------
  // alarms
  // ----------------------------------------
  wire origin_alarm = alarm_i.sensor_err || alarm_i.abspos_err ||
                      alarm_i.over_speed;
  wire any_alarm    = limit_hit || origin_alarm || alarm_i.other_alarm;
  wire any_fault    = any_alarm || alarm_i.warning;

  logic [`SST_ALM_W-1:0] alarm_code;
  assign alarm_code = alarm_i.sensor_err ? `SST_ALM_SENSOR  :
                      alarm_i.abspos_err ? `SST_ALM_ABSPOS  :
                      alarm_i.over_speed ? `SST_ALM_OVERSPD :
                      hard_ot            ? `SST_ALM_HARD_OT :
                      soft_ot            ? `SST_ALM_SOFT_OT :
                                           `SST_ALM_NONE;

  // ----------------------------------------
  // commanded position and homing
  // ----------------------------------------
  wire signed [POS_W+1:0] cmd_pos =
    $signed({2'b00, cur_pos_i}) + $signed({pos_err_i[POS_W], pos_err_i});
  wire cmd_at_zero = (cmd_pos == '0);

  logic homing_done_reg;
  logic origin_reg;
  logic homing_run_reg;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      homing_run_reg <= 1'b0;
    end else begin
      if (homing_req_s) homing_run_reg <= 1'b1;
      if (homing_done_i || homing_abort_i) homing_run_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      homing_done_reg <= 1'b0;
      origin_reg      <= 1'b0;
    end else begin
      if (homing_done_i) begin
        homing_done_reg <= 1'b1;
        origin_reg      <= 1'b1;
      end else if (!cmd_at_zero) begin
        homing_done_reg <= 1'b0;
      end
      if (origin_alarm) origin_reg <= 1'b0;
      if (homing_abort_i && homing_run_reg) origin_reg <= 1'b0;
      if (origin_alarm || homing_abort_i) homing_done_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // servo enable and brake
  // ----------------------------------------
  logic servo_lock_reg;
  logic brake_off_reg;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      servo_lock_reg <= 1'b0;
      brake_off_reg  <= 1'b0;
      servo_on_o     <= 1'b0;
    end else begin
      if (cmd_i.servo_disable_cmd) servo_lock_reg <= 1'b1;
      else if (cmd_i.servo_restore_cmd && !brake_off_reg) servo_lock_reg <= 1'b0;
      if (cmd_i.brake_release_cmd) brake_off_reg <= cmd_i.brake_release_arg;
      servo_on_o <= servo_en_s && !servo_lock_reg && !cmd_i.servo_disable_cmd &&
                    !origin_alarm && !alarm_i.other_alarm;
    end
  end

  assign brake_active_o = !brake_off_reg;

  // ----------------------------------------
  // in-position and status flags
  // ----------------------------------------
  logic inpos_reg;
  logic stop_reg;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      inpos_reg <= 1'b0;
      stop_reg  <= 1'b0;
    end else begin
      stop_reg <= limit_hit && moving_i;
      if (moving_i) inpos_reg <= 1'b0;
      else if (move_done_i && !limit_hit) inpos_reg <= 1'b1;
    end
  end

  assign stop_motion_o = stop_reg;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_o            <= '0;
      plus_limit_flag_o   <= 1'b0;
      minus_limit_flag_o  <= 1'b0;
      driver_ready_flag_o <= 1'b0;
      warning_flag_o      <= 1'b0;
      alarm_query_o       <= `SST_ALM_NONE;
    end else begin
      status_o.travel_limit_flag   <= limit_hit;
      status_o.in_position_flag    <= inpos_reg;
      status_o.healthy_flag        <= !any_fault;
      status_o.homing_done_flag    <= homing_done_reg && cmd_at_zero;
      status_o.origin_defined_flag <= origin_reg;
      plus_limit_flag_o            <= soft_plus || plus_hard_s;
      minus_limit_flag_o           <= soft_minus || minus_hard_s;
      driver_ready_flag_o          <= !any_alarm;
      warning_flag_o               <= alarm_i.warning;
      alarm_query_o                <= alarm_code;
    end
  end

  // ----------------------------------------
  // program edit teaching
  // ----------------------------------------
  sst_pkg::sst_edit_state_t edit_reg;
  sst_pkg::sst_edit_state_t edit_next;
  logic [POS_W-1:0]         shown_reg;
  logic                     shown_ang_reg;

  wire prog_capture = cmd_i.capture_suffix &&
                      (teach_target_i == `SST_TGT_AR || teach_target_i == `SST_TGT_AD);

  always_comb begin
    edit_next = edit_reg;
    unique case (edit_reg)
      sst_pkg::SST_EDIT_IDLE: if (prog_capture) edit_next = sst_pkg::SST_EDIT_SHOW;
      sst_pkg::SST_EDIT_SHOW: begin
        if (cmd_i.accept_key || cmd_i.cancel_key) edit_next = sst_pkg::SST_EDIT_DONE;
      end
      sst_pkg::SST_EDIT_DONE: edit_next = sst_pkg::SST_EDIT_IDLE;
      default:                edit_next = sst_pkg::SST_EDIT_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      edit_reg        <= sst_pkg::SST_EDIT_IDLE;
      shown_reg       <= '0;
      shown_ang_reg   <= 1'b0;
      prog_store_o    <= 1'b0;
      prog_target_o   <= '0;
      prog_is_angle_o <= 1'b0;
    end else begin
      edit_reg     <= edit_next;
      prog_store_o <= 1'b0;
      if (edit_reg == sst_pkg::SST_EDIT_IDLE && prog_capture) begin
        shown_ang_reg <= (teach_target_i == `SST_TGT_AD);
        shown_reg     <= (teach_target_i == `SST_TGT_AD) ?
                         {{(POS_W-ANG_W){1'b0}}, taught_ang} : taught_pos;
      end
      if (edit_reg == sst_pkg::SST_EDIT_SHOW && cmd_i.accept_key) begin
        prog_store_o    <= 1'b1;
        prog_target_o   <= shown_reg;
        prog_is_angle_o <= shown_ang_reg;
      end
    end
  end

  assign edit_state_o   = edit_reg;
  assign edit_display_o = shown_reg;

endmodule : sst_status_teach
